// file: verilog/tolb_defines.vh
// Register offsets, field positions and reset values of the triggered output latch bank
`ifndef TOLB_DEFINES_VH
`define TOLB_DEFINES_VH
`define TOLB_OFS_G0_LOW     3'h0
`define TOLB_OFS_G0_HIGH    3'h1
`define TOLB_OFS_G1_LOW     3'h2
`define TOLB_OFS_TRIG       3'h3
`define TOLB_OFS_G1_HIGH    3'h4
`define TOLB_OFS_G2_LOW     3'h5
`define TOLB_OFS_G2_HIGH    3'h6
`define TOLB_OFS_UNDERRUN   3'h7
`define TOLB_BIT_IMMEDIATE  0
`define TOLB_BIT_FALL_DIS   1
`define TOLB_BIT_EDGE_SEEN  2
`define TOLB_RST_IMMEDIATE  1'h0
`define TOLB_RST_FALL_DIS   1'h0
`define TOLB_RST_OUTPUTS    48'h000000000000
`define TOLB_RST_GROUP      16'h0000
`define TOLB_RST_TALLY      4'h0
`define TOLB_RST_EDGE_SEEN  1'h0
`define TOLB_RST_RDATA      8'h00
`define TOLB_TALLY_MAX      4'hF
`endif

// file: verilog/tolb_trig_sync.v
// Trigger input synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
module tolb_trig_sync (
	input  wire i_clk,
	input  wire i_rst,
	input  wire i_trig,
	output reg  o_rise,
	output reg  o_fall
);
	reg meta;
	reg stable;
	reg prev;

	// Two flops before any logic; the edge detector looks only at the second
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta   <= 1'b0;
			stable <= 1'b0;
			prev   <= 1'b0;
			o_rise <= 1'b0;
			o_fall <= 1'b0;
		end else begin
			meta   <= i_trig;
			stable <= meta;
			prev   <= stable;
			o_rise <= stable & ~prev;
			o_fall <= ~stable & prev;
		end
	end
endmodule

// file: verilog/tolb_top.v
// Triggered output latch bank: byte register port, trigger buffering, under-run tally
// Behaviour
// - Register block decodes eight consecutive byte offsets from an eight-byte aligned base.
// - Card registers live in the I/O region selected by i_bar2_sel.
// - Offset zero writes group zero bits 0-7, bit n to output n.
// - Offset one writes group zero bits 8-15, data bit 0 to output 8.
// - Offset two writes group one bits 0-7.
// - Offsets four, five, six write group one high, group two low, high.
// - Offset three is trigger control on write, trigger status on read.
// - Immediate mode drives a written byte to outputs at once.
// - Trigger mode buffers writes; rising trigger edge copies buffer to outputs.
// - Bit 0 at offset three: 0 trigger mode, 1 immediate; reads back.
// - Trigger mode, bit 1 zero: falling edge clears outputs and buffer.
// - Status bit 2 sets on rising trigger edge, clears when offset three read.
// - Four-bit tally of rising edges without output write since last; clears on read.
`timescale 1ns/1ps
`include "tolb_defines.vh"
module tolb_top (
	input  wire        i_clk,
	input  wire        i_rst,
	input  wire        i_bar2_sel,
	input  wire [15:0] i_addr,
	input  wire        i_wr,
	input  wire        i_rd,
	input  wire [7:0]  i_wdata,
	input  wire        i_ext_trigger,
	output reg  [7:0]  o_rdata,
	output reg  [15:0] o_group0_output_bit,
	output reg  [15:0] o_group1_output_bit,
	output reg  [15:0] o_group2_output_bit
);
	reg  [47:0] buffer;
	reg         immediate_select;
	reg         falling_clear_disable;
	reg         rising_edge_seen;
	reg  [3:0]  underrun_tally;
	reg         written_since_edge;
	wire        trig_rise;
	wire        trig_fall;
	wire        hit;
	wire [2:0]  ofs;
	wire        wr_hit;
	wire        rd_hit;
	wire        out_write;
	reg  [47:0] next_buffer;
	reg  [7:0]  next_rdata;

	// Maps a byte offset to its lane in the 48-bit output image, 7 for none
	function [2:0] lane_of;
		input [2:0] o;
		begin
			case (o)
				`TOLB_OFS_G0_LOW:  lane_of = 3'h0;
				`TOLB_OFS_G0_HIGH: lane_of = 3'h1;
				`TOLB_OFS_G1_LOW:  lane_of = 3'h2;
				`TOLB_OFS_G1_HIGH: lane_of = 3'h3;
				`TOLB_OFS_G2_LOW:  lane_of = 3'h4;
				`TOLB_OFS_G2_HIGH: lane_of = 3'h5;
				default:           lane_of = 3'h7;
			endcase
		end
	endfunction

	tolb_trig_sync u_sync (
		.i_clk  (i_clk),
		.i_rst  (i_rst),
		.i_trig (i_ext_trigger),
		.o_rise (trig_rise),
		.o_fall (trig_fall)
	);

	// Low three address bits select the register; upper bits are the aligned base
	assign hit       = i_bar2_sel;
	assign ofs       = i_addr[2:0];
	assign wr_hit    = hit & i_wr;
	assign rd_hit    = hit & i_rd;
	assign out_write = wr_hit & (lane_of(ofs) != 3'h7);

	// Buffer image: a write overwrites its byte lane, so the last write wins
	always @* begin
		next_buffer = buffer;
		if (out_write) begin
			case (lane_of(ofs))
				3'h0:    next_buffer[7:0]   = i_wdata;
				3'h1:    next_buffer[15:8]  = i_wdata;
				3'h2:    next_buffer[23:16] = i_wdata;
				3'h3:    next_buffer[31:24] = i_wdata;
				3'h4:    next_buffer[39:32] = i_wdata;
				3'h5:    next_buffer[47:40] = i_wdata;
				default: next_buffer = buffer;
			endcase
		end
	end

	// Buffer and outputs; a write in the same cycle as a rising edge is not lost
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			buffer              <= `TOLB_RST_OUTPUTS;
			o_group0_output_bit <= `TOLB_RST_GROUP;
			o_group1_output_bit <= `TOLB_RST_GROUP;
			o_group2_output_bit <= `TOLB_RST_GROUP;
		end else if (immediate_select) begin
			buffer              <= next_buffer;
			o_group0_output_bit <= next_buffer[15:0];
			o_group1_output_bit <= next_buffer[31:16];
			o_group2_output_bit <= next_buffer[47:32];
		end else if (trig_rise) begin
			buffer              <= next_buffer;
			o_group0_output_bit <= buffer[15:0];
			o_group1_output_bit <= buffer[31:16];
			o_group2_output_bit <= buffer[47:32];
		end else if (trig_fall && !falling_clear_disable) begin
			buffer              <= `TOLB_RST_OUTPUTS;
			o_group0_output_bit <= 16'h0000;
			o_group1_output_bit <= 16'h0000;
			o_group2_output_bit <= 16'h0000;
		end else begin
			buffer <= next_buffer;
		end
	end

	// Control bits written at offset three
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			immediate_select      <= `TOLB_RST_IMMEDIATE;
			falling_clear_disable <= `TOLB_RST_FALL_DIS;
		end else if (wr_hit && ofs == `TOLB_OFS_TRIG) begin
			immediate_select      <= i_wdata[`TOLB_BIT_IMMEDIATE];
			falling_clear_disable <= i_wdata[`TOLB_BIT_FALL_DIS];
		end
	end

	// Edge flag: a set in the same cycle as the read-clear wins
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rising_edge_seen <= `TOLB_RST_EDGE_SEEN;
		end else if (trig_rise) begin
			rising_edge_seen <= 1'b1;
		end else if (rd_hit && ofs == `TOLB_OFS_TRIG) begin
			rising_edge_seen <= 1'b0;
		end
	end

	// Under-run tally saturates at fifteen rather than wrapping to a misleading small count
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			underrun_tally     <= `TOLB_RST_TALLY;
			written_since_edge <= 1'b0;
		end else begin
			if (trig_rise) begin
				written_since_edge <= out_write;
			end else if (out_write) begin
				written_since_edge <= 1'b1;
			end
			if (trig_rise && !written_since_edge && !out_write) begin
				if (rd_hit && ofs == `TOLB_OFS_UNDERRUN) begin
					underrun_tally <= 4'h1;
				end else if (underrun_tally != `TOLB_TALLY_MAX) begin
					underrun_tally <= underrun_tally + 4'h1;
				end
			end else if (rd_hit && ofs == `TOLB_OFS_UNDERRUN) begin
				underrun_tally <= 4'h0;
			end
		end
	end

	// Read data, registered; write-only offsets read zero
	always @* begin
		next_rdata = 8'h00;
		case (ofs)
			`TOLB_OFS_TRIG:     next_rdata = {5'h00, rising_edge_seen, falling_clear_disable,
			                                  immediate_select};
			`TOLB_OFS_UNDERRUN: next_rdata = {4'h0, underrun_tally};
			default:            next_rdata = 8'h00;
		endcase
	end

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= `TOLB_RST_RDATA;
		end else if (rd_hit) begin
			o_rdata <= next_rdata;
		end
	end
endmodule

// file: testbench/tolb_trig_src.sv
// External trigger source model for the latch bank
`timescale 1ns/1ps
module tolb_trig_src (
	input  wire       i_clk,
	input  wire       i_go,
	input  wire [3:0] i_width,
	output reg        o_trig
);
	reg [3:0] cnt = 4'h0;
	initial o_trig = 1'b0;
	// High for i_width plus one cycles per start; keep width above the synchroniser depth
	always @(posedge i_clk) begin
		if (i_go) begin
			o_trig <= 1'b1;
			cnt    <= i_width;
		end else if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
		else
			o_trig <= 1'b0;
	end
endmodule

// file: testbench/tolb_top_chk.sv
// Port checker for the triggered output latch bank
`timescale 1ns/1ps
module tolb_chk (
	input wire        i_clk,
	input wire        i_rst,
	input wire        i_bar2_sel,
	input wire [15:0] i_addr,
	input wire        i_wr,
	input wire        i_rd,
	input wire [7:0]  i_wdata,
	input wire        i_ext_trigger,
	input wire [7:0]  o_rdata,
	input wire [15:0] o_group0_output_bit,
	input wire [15:0] o_group1_output_bit,
	input wire [15:0] o_group2_output_bit
);
	reg  [1:0]  ctl;
	reg  [3:0]  q;
	reg         tp;
	wire        w    = i_bar2_sel & i_wr;
	wire        r    = i_bar2_sel & i_rd;
	wire [2:0]  a    = i_addr[2:0];
	wire [47:0] outs = {o_group2_output_bit, o_group1_output_bit, o_group0_output_bit};
	// Control shadow, and cycles since the trigger pin last moved (sync delay margin)
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctl <= 2'h0;
			q   <= 4'h0;
			tp  <= 1'b0;
		end else begin
			tp  <= i_ext_trigger;
			q   <= (i_ext_trigger != tp) ? 4'h0 : ((q == 4'hF) ? q : q + 4'h1);
			if (w && a == 3'h3)
				ctl <= i_wdata[1:0];
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_imm_low0: assert property (ctl[0] && w && a == 3'h0 |=> outs[7:0] == $past(i_wdata)) else $error("imm low0");
	a_imm_g1hi: assert property (ctl[0] && w && a == 3'h4 |=> outs[31:24] == $past(i_wdata)) else $error("imm g1hi");
	a_rd_blank: assert property (r && a == 3'h0 |=> o_rdata == 8'h00) else $error("blank read");
	a_ctl_back: assert property (r && a == 3'h3 |=> o_rdata[7:3] == 5'h0 && o_rdata[1:0] == $past(ctl)) else $error("ctl read");
	a_tally_top: assert property (r && a == 3'h7 |=> o_rdata[7:4] == 4'h0) else $error("tally read");
	a_trig_hold: assert property (!ctl[0] && !$past(ctl[0]) && q > 4'h5 |-> $stable(outs)) else $error("buffer leak");
	a_fall_clear: assert property (ctl == 2'h0 && $fell(i_ext_trigger) |-> ##[2:6] outs == 48'h0) else $error("no clear");
	a_idle_hold: assert property (!i_bar2_sel && q > 4'h5 |=> $stable(outs)) else $error("unselected change");
	c_imm: cover property (ctl[0] && w && a == 3'h0);
	c_fall: cover property (ctl == 2'h0 && $fell(i_ext_trigger));
	c_tally: cover property (r && a == 3'h7);
endmodule
bind tolb_top tolb_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_bar2_sel(i_bar2_sel), .i_addr(i_addr), .i_wr(i_wr),
	.i_rd(i_rd), .i_wdata(i_wdata), .i_ext_trigger(i_ext_trigger), .o_rdata(o_rdata),
	.o_group0_output_bit(o_group0_output_bit), .o_group1_output_bit(o_group1_output_bit),
	.o_group2_output_bit(o_group2_output_bit));

// file: testbench/tolb_top_bench.sv
// Self-checking bench for the triggered output latch bank
`timescale 1ns/1ps
module tolb_top_bench;
	reg         clk = 0, rst = 1, sel = 0, wr = 0, rd = 0, go = 0, imm = 0;
	reg  [15:0] addr = 16'h0;
	reg  [7:0]  wdata = 8'h00;
	reg  [3:0]  wid = 4'h6;
	reg  [47:0] outm = 48'h0, pend = 48'h0;
	wire        trig;
	wire [7:0]  rdata;
	wire [15:0] g0, g1, g2;
	wire [47:0] outs = {g2, g1, g0};
	integer     seed = 32'hf996, bad_count = 0, compares = 0, i;
	initial forever #25 clk = ~clk;
	tolb_top dut (.i_clk(clk), .i_rst(rst), .i_bar2_sel(sel), .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata),
		.i_ext_trigger(trig), .o_rdata(rdata), .o_group0_output_bit(g0), .o_group1_output_bit(g1),
		.o_group2_output_bit(g2));
	tolb_trig_src src (.i_clk(clk), .i_go(go), .i_width(wid), .o_trig(trig));
	// Byte slot of an output offset; offset three is not an output byte
	function integer slot(input [2:0] a);
		slot = (a < 3'h3) ? a : a - 1;
	endfunction
	task chk(input [47:0] seen, input [47:0] want);
		compares = compares + 1;
		if (seen !== want) begin
			bad_count = bad_count + 1;
			$display("Error at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	// Random base above the low three bits checks alignment decoding
	task wrb(input [2:0] a, input [7:0] d);
		@(posedge clk);
		sel <= 1; addr <= {13'($random(seed)), a}; wdata <= d; wr <= 1;
		@(posedge clk);
		sel <= 0; wr <= 0;
		if (a != 3'h3 && a != 3'h7) begin
			pend[8*slot(a)+:8] = d;
			if (imm) outm = pend;
		end
	endtask
	task rdb(input [2:0] a, input [7:0] e);
		@(posedge clk);
		sel <= 1; addr <= {13'($random(seed)), a}; rd <= 1;
		@(posedge clk);
		sel <= 0; rd <= 0;
		@(negedge clk) chk({40'h0, rdata}, {40'h0, e});
	endtask
	// Rising edge copies the buffer to the outputs; the fall clears both when enabled
	task pulse(input clr);
		@(posedge clk) go <= 1;
		@(posedge clk) go <= 0;
		repeat (20) @(posedge clk);
		outm = pend;
		if (clr) begin
			outm = 48'h0; pend = 48'h0;
		end
	endtask
	task wrap_up;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#1000000 bad_count = bad_count + 1;
		wrap_up;
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 0;
		@(negedge clk) chk(outs, 48'h0);
		rdb(3, 8'h00);
		$display("test reset done");
		wrb(3, 8'h01); imm = 1;
		for (i = 0; i < 7; i = i + 1) if (i != 3) begin
			wrb(3'(i), 8'($random(seed)));
			@(negedge clk) chk(outs, outm);
		end
		wrb(7, 8'hFF);
		@(negedge clk) chk(outs, outm);
		// Write strobe without the region select must leave the outputs alone
		@(posedge clk) addr <= 16'h0000;
		wdata <= 8'h5A;
		wr <= 1;
		@(posedge clk) wr <= 0;
		@(negedge clk) chk(outs, outm);
		rdb(0, 8'h00);
		rdb(5, 8'h00);
		wrb(3, 8'h03);
		rdb(3, 8'h03);
		$display("test immediate done");
		wrb(3, 8'h02); imm = 0;
		rdb(7, 8'h00);
		for (i = 0; i < 14; i = i + 1) if (i % 7 != 3) wrb(3'(i % 7), 8'($random(seed)));
		@(negedge clk) chk(outs, outm);
		pulse(0);
		chk(outs, outm);
		rdb(3, 8'h06);
		rdb(3, 8'h02);
		pulse(0);
		chk(outs, outm);
		rdb(7, 8'h01);
		rdb(7, 8'h00);
		wrb(3, 8'h00);
		wrb(0, 8'hA5);
		pulse(1);
		chk(outs, 48'h0);
		$display("test trigger done");
		// Sixteen unwritten rising edges push the tally past its ceiling
		for (i = 0; i < 16; i = i + 1) pulse(1);
		rdb(7, 8'h0F);
		rdb(7, 8'h00);
		rdb(3, 8'h04);
		chk(outs, 48'h0);
		$display("test saturation done");
		wrap_up;
	end
endmodule
